/* common/cca_pkg.sv */
// Constants for the calendar clock access block.
// Assumes a 32-bit AHB-Lite slave with byte-wide registers on word addresses.
package cca_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CFG_OFF    = 8'h00;
    localparam logic [7:0] UNLOCK_OFF = 8'h04;
    localparam logic [7:0] VALH_OFF   = 8'h08;
    localparam logic [7:0] VALL_OFF   = 8'h0c;
    localparam logic [7:0] ACFG_OFF   = 8'h10;
    localparam logic [7:0] ALH_OFF    = 8'h14;
    localparam logic [7:0] ALL_OFF    = 8'h18;
    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         CFG_EN_BIT   = 7;
    localparam int         CFG_WREN_BIT = 5;
    localparam int         CFG_SYNC_BIT = 4;
    localparam int         CFG_HALF_BIT = 3;
    localparam logic [1:0] PTR_RST      = 2'h0;
    localparam logic [1:0] PTR_MINUTE_SECOND_PAIR   = 2'h0;
    localparam logic [1:0] PTR_WDHR     = 2'h1;
    localparam logic [1:0] PTR_MODAY    = 2'h2;
    localparam logic [1:0] PTR_YEAR     = 2'h3;
    localparam logic [7:0] UNLOCK_KEY1  = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2  = 8'haa;
    // ------------------------------------------------------------------
    // Calendar fields: load vector index, limits, reset values
    // ------------------------------------------------------------------
    localparam int         FLD_SEC   = 0;
    localparam int         FLD_MIN   = 1;
    localparam int         FLD_HOUR  = 2;
    localparam int         FLD_WDAY  = 3;
    localparam int         FLD_DAY   = 4;
    localparam int         FLD_MONTH = 5;
    localparam int         FLD_YEAR  = 6;
    localparam int         FLD_NUM   = 7;
    localparam logic [7:0] SEC_MAX   = 8'h3b;
    localparam logic [7:0] HOUR_MAX  = 8'h17;
    localparam logic [7:0] WDAY_MAX  = 8'h06;
    localparam logic [7:0] MONTH_MAX = 8'h0c;
    localparam logic [7:0] FEB       = 8'h02;
    localparam logic [7:0] YEAR_MAX  = 8'h63;
    localparam logic [7:0] ZERO_RST  = 8'h00;
    localparam logic [7:0] ONE_RST   = 8'h01;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int HALF_SEC_NS      = 500_000_000;
    localparam int HALF_SEC_CYCLES  = HALF_SEC_NS / CLK_PERIOD_NS;
    localparam int SYNC_LEAD_CYCLES = 32;
endpackage : cca_pkg

/* hdl/cca_unlock.sv */
// Two-byte unlock sequence tracker for the time write enable.
// Assumes one strobe per completed bus write, with its byte and target.
module cca_unlock
    import cca_pkg::*;
(
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Write stream
    input  wire logic       wr_take,
    input  wire logic       wr_unlock,
    input  wire logic [7:0] wr_byte,
    // Result
    output logic            armed
);
    // ------------------------------------------------------------------
    // Sequence state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {UNL_IDLE, UNL_GOT1, UNL_ARMED} cca_unl_t;
    cca_unl_t state_ff;
    cca_unl_t nxt_state;

    wire key1 = wr_unlock & (wr_byte == UNLOCK_KEY1);
    wire key2 = wr_unlock & (wr_byte == UNLOCK_KEY2);

    // Any other write, the arming write included, drops the window
    assign nxt_state = !wr_take                   ? state_ff  :
                       key1                       ? UNL_GOT1  :
                       (key2 && state_ff == UNL_GOT1) ? UNL_ARMED : UNL_IDLE;
    assign armed = (state_ff == UNL_ARMED);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) state_ff <= UNL_IDLE;
        else          state_ff <= nxt_state;
    end

    property p_arm;
        @(posedge hclk) disable iff (!hresetn)
        (wr_take && key2 && state_ff == UNL_GOT1) |=> armed;
    endproperty
    a_arm: assert property (p_arm) else $error("unlock not armed after key pair");

    property p_one_slot;
        @(posedge hclk) disable iff (!hresetn)
        (armed && wr_take) |=> !armed;
    endproperty
    a_one_slot: assert property (p_one_slot) else $error("unlock window too long");
endmodule : cca_unlock

/* hdl/cca_calendar.sv */
// Binary calendar counter with per-field loads.
// Assumes a one-cycle seconds tick and one-hot field load strobes.
module cca_calendar
    import cca_pkg::*;
(
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // Control
    input  wire logic               sec_tick,
    input  wire logic [FLD_NUM-1:0] ld,
    input  wire logic [7:0]         ld_data,
    // Time fields
    output logic [7:0]              fld [FLD_NUM]
);
    logic [7:0] fld_ff  [FLD_NUM];
    logic [7:0] nxt_fld [FLD_NUM];
    logic [7:0] lo      [FLD_NUM];
    logic [7:0] dim;
    logic [FLD_NUM-1:0] inc;
    logic [FLD_NUM-1:0] wrap;

    // Leap years are those divisible by four
    assign dim = (fld_ff[FLD_MONTH] == FEB) ? ((fld_ff[FLD_YEAR][1:0] == 2'h0) ? 8'h1d : 8'h1c) :
                 (fld_ff[FLD_MONTH] == 8'h04 || fld_ff[FLD_MONTH] == 8'h06 ||
                  fld_ff[FLD_MONTH] == 8'h09 || fld_ff[FLD_MONTH] == 8'h0b) ? 8'h1e : 8'h1f;

    // Carry chain keeps running while other fields are loaded
    assign wrap[FLD_SEC]   = fld_ff[FLD_SEC] >= SEC_MAX;
    assign wrap[FLD_MIN]   = fld_ff[FLD_MIN] >= SEC_MAX;
    assign wrap[FLD_HOUR]  = fld_ff[FLD_HOUR] >= HOUR_MAX;
    assign wrap[FLD_WDAY]  = fld_ff[FLD_WDAY] >= WDAY_MAX;
    assign wrap[FLD_DAY]   = fld_ff[FLD_DAY] >= dim;
    assign wrap[FLD_MONTH] = fld_ff[FLD_MONTH] >= MONTH_MAX;
    assign wrap[FLD_YEAR]  = fld_ff[FLD_YEAR] >= YEAR_MAX;
    assign inc[FLD_SEC]    = sec_tick;
    assign inc[FLD_MIN]    = inc[FLD_SEC] & wrap[FLD_SEC];
    assign inc[FLD_HOUR]   = inc[FLD_MIN] & wrap[FLD_MIN];
    assign inc[FLD_WDAY]   = inc[FLD_HOUR] & wrap[FLD_HOUR];
    assign inc[FLD_DAY]    = inc[FLD_WDAY];
    assign inc[FLD_MONTH]  = inc[FLD_DAY] & wrap[FLD_DAY];
    assign inc[FLD_YEAR]   = inc[FLD_MONTH] & wrap[FLD_MONTH];

    for (genvar i = 0; i < FLD_NUM; i++) begin : g_fld
        assign lo[i] = (i == FLD_DAY || i == FLD_MONTH) ? ONE_RST : ZERO_RST;
        // Load wins over a same-cycle increment
        assign nxt_fld[i] = ld[i]  ? ld_data :
                            inc[i] ? (wrap[i] ? lo[i] : 8'(fld_ff[i] + 8'h01)) : fld_ff[i];
        assign fld[i] = fld_ff[i];
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) fld_ff[i] <= (i == FLD_DAY || i == FLD_MONTH) ? ONE_RST : ZERO_RST;
            else          fld_ff[i] <= nxt_fld[i];
        end
    end

    property p_load;
        @(posedge hclk) disable iff (!hresetn)
        ld[FLD_SEC] |=> fld_ff[FLD_SEC] == $past(ld_data);
    endproperty
    a_load: assert property (p_load) else $error("loaded seconds not kept");

    property p_feb;
        @(posedge hclk) disable iff (!hresetn)
        (inc[FLD_MONTH] && fld_ff[FLD_MONTH] == FEB) |->
            fld_ff[FLD_DAY] == ((fld_ff[FLD_YEAR][1:0] == 2'h0) ? 8'h1d : 8'h1c);
    endproperty
    a_feb: assert property (p_feb) else $error("wrong February length");
endmodule : cca_calendar

/* hdl/cca_clock_access.sv */
// Calendar clock access: AHB-Lite register slave, prescaler and windows.
// Assumes a single AHB-Lite master, word transfers, and one clock domain.
//
// Notes on behaviour
// - Seconds through year fields are all writable by software.
// - Counting resumes from the values that software wrote.
// - Calendar runs only while config bit 7 is set.
// - Counting continues while software adjusts the time fields.
// - Any minute/second pair write resets the divider to zero; only a seconds write clears the half stage.
// - A time write lands at the end of its own data phase.
// - Config bit 4 low means access is safe from rollover.
// - Half-second field is read-only, cleared by writing seconds.
// - Time writes take effect only while config bit 5 is set.
// - Bit 5 sets only right after writing 55h then AAh to unlock.
// - Config bits 1:0 select the pair shown in the value windows.
// - Each high value window access decrements the pointer, stopping at 00.
// - Pointer 00 min/sec, 01 wday/hour, 10 month/day, 11 none/year.
// - Alarm config bits 1:0 select the pair in the alarm windows.
// - Each high alarm window access decrements the alarm pointer to 00.
// - Years divisible by four give February 29 days, else 28.
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
module cca_clock_access
    import cca_pkg::*;
#(
    parameter int HALF_CYCLES = HALF_SEC_CYCLES,
    parameter int SYNC_LEAD   = SYNC_LEAD_CYCLES
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite address phase
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    // AHB-Lite data phase
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    localparam int DIV_W = $clog2(HALF_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYCLES - 1);
    localparam logic [DIV_W-1:0] SYNC_AT  = DIV_W'(HALF_CYCLES - 1 - SYNC_LEAD);
    localparam int ALM_NUM = 6;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [1:0] dec_ptr(input logic [1:0] p);
        dec_ptr = (p == PTR_MINUTE_SECOND_PAIR) ? PTR_MINUTE_SECOND_PAIR : 2'(p - 2'h1);
    endfunction : dec_ptr

    function automatic logic is_reg(input logic [31:0] a, input logic [7:0] off);
        is_reg = (a[31:8] == 24'h000000) && (a[7:0] == off);
    endfunction : is_reg

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic             dp_wr_ff;
    logic [31:0]      dp_addr_ff;
    logic [31:0]      hrdata_ff;
    logic             hreadyout_ff;
    logic             en_ff;
    logic             wren_ff;
    logic [1:0]       ptr_ff;
    logic [1:0]       aptr_ff;
    logic [DIV_W-1:0] div_ff;
    logic             half_ff;
    logic             sync_ff;
    logic [7:0]       alm_ff [ALM_NUM];
    logic [7:0]       fld [FLD_NUM];
    logic             armed;

    // ------------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------------
    wire       ap_take = hsel & hready & htrans[1];
    wire       rd_take = ap_take & ~hwrite;
    wire       wr_take = dp_wr_ff;
    wire [7:0] wd      = hwdata[7:0];

    wire wr_cfg    = wr_take & is_reg(dp_addr_ff, CFG_OFF);
    wire wr_unlock = wr_take & is_reg(dp_addr_ff, UNLOCK_OFF);
    wire wr_valh   = wr_take & is_reg(dp_addr_ff, VALH_OFF);
    wire wr_vall   = wr_take & is_reg(dp_addr_ff, VALL_OFF);
    wire wr_acfg   = wr_take & is_reg(dp_addr_ff, ACFG_OFF);
    wire wr_alh    = wr_take & is_reg(dp_addr_ff, ALH_OFF);
    wire wr_all    = wr_take & is_reg(dp_addr_ff, ALL_OFF);

    wire rd_cfg    = rd_take & is_reg(haddr, CFG_OFF);
    wire rd_valh   = rd_take & is_reg(haddr, VALH_OFF);
    wire rd_vall   = rd_take & is_reg(haddr, VALL_OFF);
    wire rd_acfg   = rd_take & is_reg(haddr, ACFG_OFF);
    wire rd_alh    = rd_take & is_reg(haddr, ALH_OFF);
    wire rd_all    = rd_take & is_reg(haddr, ALL_OFF);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_ff   <= 1'b0;
            dp_addr_ff <= 32'h00000000;
        end else begin
            dp_wr_ff   <= ap_take & hwrite;
            dp_addr_ff <= ap_take ? haddr : dp_addr_ff;
        end
    end

    // ------------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------------
    cca_unlock u_unlock (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .wr_take   (wr_take),
        .wr_unlock (wr_unlock),
        .wr_byte   (wd),
        .armed     (armed)
    );

    // ------------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------------
    wire       nxt_en   = wr_cfg ? wd[CFG_EN_BIT] : en_ff;
    // Clearing is always allowed, setting needs the armed slot
    wire       nxt_wren = wr_cfg ? (wd[CFG_WREN_BIT] & (wren_ff | armed)) : wren_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_ff   <= 1'b0;
            wren_ff <= 1'b0;
        end else begin
            en_ff   <= nxt_en;
            wren_ff <= nxt_wren;
        end
    end

    // ------------------------------------------------------------------
    // Window pointers
    // ------------------------------------------------------------------
    wire       val_hi_acc = rd_valh | wr_valh;
    wire       alm_hi_acc = rd_alh | wr_alh;
    wire [1:0] nxt_ptr    = wr_cfg     ? wd[1:0]         :
                            val_hi_acc ? dec_ptr(ptr_ff) : ptr_ff;
    wire [1:0] nxt_aptr   = wr_acfg    ? wd[1:0]          :
                            alm_hi_acc ? dec_ptr(aptr_ff) : aptr_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_ff  <= PTR_RST;
            aptr_ff <= PTR_RST;
        end else begin
            ptr_ff  <= nxt_ptr;
            aptr_ff <= nxt_aptr;
        end
    end

    // ------------------------------------------------------------------
    // Time field loads
    // ------------------------------------------------------------------
    wire tw_h = wr_valh & wren_ff;
    wire tw_l = wr_vall & wren_ff;
    wire [FLD_NUM-1:0] ld;

    assign ld[FLD_MIN]   = tw_h & (ptr_ff == PTR_MINUTE_SECOND_PAIR);
    assign ld[FLD_WDAY]  = tw_h & (ptr_ff == PTR_WDHR);
    assign ld[FLD_MONTH] = tw_h & (ptr_ff == PTR_MODAY);
    assign ld[FLD_SEC]   = tw_l & (ptr_ff == PTR_MINUTE_SECOND_PAIR);
    assign ld[FLD_HOUR]  = tw_l & (ptr_ff == PTR_WDHR);
    assign ld[FLD_DAY]   = tw_l & (ptr_ff == PTR_MODAY);
    assign ld[FLD_YEAR]  = tw_l & (ptr_ff == PTR_YEAR);

    wire minute_second_pair_wr = ld[FLD_MIN] | ld[FLD_SEC];

    // ------------------------------------------------------------------
    // Prescalers: cycle divider and half-second stage
    // ------------------------------------------------------------------
    wire div_end  = en_ff & (div_ff == DIV_LAST);
    wire sec_tick = div_end & half_ff;
    wire [DIV_W-1:0] nxt_div = minute_second_pair_wr ? '0 :
                               !en_ff    ? div_ff :
                               div_end   ? '0 : DIV_W'(div_ff + 1'b1);
    // Half stage clears on a seconds write only; minutes restart the divider
    wire sec_wr   = ld[FLD_SEC];
    wire nxt_half = sec_wr    ? 1'b0 :
                    minute_second_pair_wr ? half_ff :
                    div_end   ? ~half_ff : half_ff;
    // Flag rises ahead of each seconds rollover except one in the first cycle after enabling
    wire nxt_sync = en_ff & half_ff & (div_ff >= SYNC_AT) & ~minute_second_pair_wr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff  <= '0;
            half_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            div_ff  <= nxt_div;
            half_ff <= nxt_half;
            sync_ff <= nxt_sync;
        end
    end

    // ------------------------------------------------------------------
    // Calendar counter
    // ------------------------------------------------------------------
    cca_calendar u_calendar (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .sec_tick (sec_tick),
        .ld       (ld),
        .ld_data  (wd),
        .fld      (fld)
    );

    // ------------------------------------------------------------------
    // Alarm storage, indexed by pointer and half
    // ------------------------------------------------------------------
    wire [2:0] alm_wr_idx = {aptr_ff, wr_alh};
    wire       alm_wr     = (wr_alh | wr_all) & (alm_wr_idx < 3'(ALM_NUM));

    for (genvar i = 0; i < ALM_NUM; i++) begin : g_alm
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) alm_ff[i] <= ZERO_RST;
            else if (alm_wr && alm_wr_idx == 3'(i)) alm_ff[i] <= wd;
        end
    end

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    wire [7:0] valh_byte = (ptr_ff == PTR_MINUTE_SECOND_PAIR) ? fld[FLD_MIN]   :
                           (ptr_ff == PTR_WDHR)   ? fld[FLD_WDAY]  :
                           (ptr_ff == PTR_MODAY)  ? fld[FLD_MONTH] : 8'h00;
    wire [7:0] vall_byte = (ptr_ff == PTR_MINUTE_SECOND_PAIR) ? fld[FLD_SEC]   :
                           (ptr_ff == PTR_WDHR)   ? fld[FLD_HOUR]  :
                           (ptr_ff == PTR_MODAY)  ? fld[FLD_DAY]   : fld[FLD_YEAR];
    wire [2:0] alh_idx   = {aptr_ff, 1'b1};
    wire [2:0] all_idx   = {aptr_ff, 1'b0};
    wire [7:0] alh_byte  = (alh_idx < 3'(ALM_NUM)) ? alm_ff[alh_idx] : 8'h00;
    wire [7:0] all_byte  = (all_idx < 3'(ALM_NUM)) ? alm_ff[all_idx] : 8'h00;
    wire [7:0] cfg_byte  = {en_ff, 1'b0, wren_ff, sync_ff, half_ff, 1'b0, ptr_ff};
    wire [7:0] rd_byte   = rd_cfg  ? cfg_byte           :
                           rd_valh ? valh_byte          :
                           rd_vall ? vall_byte          :
                           rd_acfg ? {6'h00, aptr_ff}   :
                           rd_alh  ? alh_byte           :
                           rd_all  ? all_byte           : 8'h00;

    // ------------------------------------------------------------------
    // Bus outputs
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff    <= 32'h00000000;
            hreadyout_ff <= 1'b0;
        end else begin
            hrdata_ff    <= rd_take ? {24'h000000, rd_byte} : hrdata_ff;
            hreadyout_ff <= 1'b1;
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_ptr_dec;
        @(posedge hclk) disable iff (!hresetn)
        (val_hi_acc && !wr_cfg && ptr_ff != PTR_MINUTE_SECOND_PAIR) |=> ptr_ff == 2'($past(ptr_ff) - 2'h1);
    endproperty
    a_ptr_dec: assert property (p_ptr_dec) else $error("value pointer did not step");

    property p_ptr_sat;
        @(posedge hclk) disable iff (!hresetn)
        (val_hi_acc && !wr_cfg && ptr_ff == PTR_MINUTE_SECOND_PAIR) |=> ptr_ff == PTR_MINUTE_SECOND_PAIR;
    endproperty
    a_ptr_sat: assert property (p_ptr_sat) else $error("value pointer left 00");

    property p_aptr_dec;
        @(posedge hclk) disable iff (!hresetn)
        (alm_hi_acc && !wr_acfg) |=> aptr_ff == dec_ptr($past(aptr_ff));
    endproperty
    a_aptr_dec: assert property (p_aptr_dec) else $error("alarm pointer did not step");

    property p_wren_set;
        @(posedge hclk) disable iff (!hresetn)
        $rose(wren_ff) |-> $past(armed) && $past(wr_cfg);
    endproperty
    a_wren_set: assert property (p_wren_set) else $error("write enable set unarmed");

    property p_locked;
        @(posedge hclk) disable iff (!hresetn)
        (ld != '0) |-> wren_ff && wr_take;
    endproperty
    a_locked: assert property (p_locked) else $error("time load while locked");

    property p_prescale;
        @(posedge hclk) disable iff (!hresetn)
        minute_second_pair_wr |=> div_ff == '0 && !sync_ff;
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescalers not cleared");

    property p_half_clr;
        @(posedge hclk) disable iff (!hresetn)
        sec_wr |=> !half_ff;
    endproperty
    a_half_clr: assert property (p_half_clr) else $error("half second not cleared");

    property p_half_keep;
        @(posedge hclk) disable iff (!hresetn)
        (ld[FLD_MIN] && !sec_wr) |=> half_ff == $past(half_ff);
    endproperty
    a_half_keep: assert property (p_half_keep) else $error("half second moved on minutes");

    property p_wr_dropped;
        @(posedge hclk) disable iff (!hresetn)
        (wr_vall && !wren_ff && !sec_tick) |=> fld[FLD_SEC] == $past(fld[FLD_SEC]);
    endproperty
    a_wr_dropped: assert property (p_wr_dropped) else $error("locked write changed seconds");

    property p_year_window;
        @(posedge hclk) disable iff (!hresetn)
        (rd_vall && ptr_ff == PTR_YEAR) |=> hrdata_ff[7:0] == $past(fld[FLD_YEAR]);
    endproperty
    a_year_window: assert property (p_year_window) else $error("year window wrong");

    property p_ptr_load;
        @(posedge hclk) disable iff (!hresetn)
        wr_cfg |=> ptr_ff == $past(wd[1:0]);
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("value pointer not loaded");

    property p_stopped;
        @(posedge hclk) disable iff (!hresetn)
        !en_ff |-> !sec_tick ##1 (div_ff == $past(div_ff) || $past(minute_second_pair_wr) || $past(wr_cfg));
    endproperty
    a_stopped: assert property (p_stopped) else $error("counting while disabled");

    property p_sync;
        @(posedge hclk) disable iff (!hresetn)
        (sec_tick && $past(en_ff) && $past(half_ff)) |-> sync_ff;
    endproperty
    a_sync: assert property (p_sync) else $error("rollover without sync flag");
endmodule : cca_clock_access

/* testbench/tb_cca_clock_access.sv */
// Self-checking bench for the calendar clock access block.
// Assumes an AHB-Lite master model here, hready looped from hreadyout.
module tb_cca_clock_access
    import cca_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------------
    logic        hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp;
    int          fail_count, check_count, n, k;
    cca_clock_access #(.HALF_CYCLES(20), .SYNC_LEAD(4)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic waitrdy;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            test_done();
        end
    endtask : waitrdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        waitrdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitrdy();
        rdv = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, rdv, {24'h0, e});
    endtask : rd
    task automatic unlock;
        wr(UNLOCK_OFF, UNLOCK_KEY1);
        wr(UNLOCK_OFF, UNLOCK_KEY2);
    endtask : unlock
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        fail_count = 0;
        check_count = 0;
        hresetn = 1'b0;
        hsel = 1'b1;
        hsize = 3'h2;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd("cfg reset", CFG_OFF, 8'h00);
        rd("unmapped", 8'h1c, 8'h00);
        wr(CFG_OFF, 8'h20);
        rd("wren locked", CFG_OFF, 8'h00);
        wr(VALL_OFF, 8'h09);
        rd("sec locked", VALL_OFF, 8'h00);
        unlock();
        wr(CFG_OFF, 8'h23);
        rd("cfg unlocked", CFG_OFF, 8'h23);
        wr(VALL_OFF, 8'h10);
        chk("resp", {31'h0, hresp}, 32'h0);
        wr(VALH_OFF, 8'h00);
        wr(VALL_OFF, 8'h07);
        wr(VALH_OFF, 8'h05);
        wr(VALL_OFF, 8'h03);
        wr(VALH_OFF, 8'h02);
        wr(VALL_OFF, 8'h1e);
        wr(VALH_OFF, 8'h0a);
        rd("ptr floor", CFG_OFF, 8'h20);
        wr(CFG_OFF, 8'h03);
        repeat (50) @(posedge hclk);
        rd("year", VALL_OFF, 8'h10);
        rd("none", VALH_OFF, 8'h00);
        rd("day", VALL_OFF, 8'h07);
        rd("month", VALH_OFF, 8'h05);
        rd("hour", VALL_OFF, 8'h03);
        rd("wday", VALH_OFF, 8'h02);
        rd("sec halted", VALL_OFF, 8'h1e);
        rd("min", VALH_OFF, 8'h0a);
        rd("min again", VALH_OFF, 8'h0a);
        wr(VALL_OFF, 8'h05);
        rd("sec wren off", VALL_OFF, 8'h1e);
        wr(ACFG_OFF, 8'h02);
        wr(ALH_OFF, 8'h11);
        rd("aptr dec", ACFG_OFF, 8'h01);
        wr(ALH_OFF, 8'h22);
        wr(ALL_OFF, 8'h33);
        wr(ALH_OFF, 8'h44);
        rd("asec", ALL_OFF, 8'h33);
        rd("amin", ALH_OFF, 8'h44);
        rd("aptr floor", ACFG_OFF, 8'h00);
        wr(CFG_OFF, 8'h80);
        repeat (85) @(posedge hclk);
        rd("sec counted", VALL_OFF, 8'h20);
        unlock();
        wr(CFG_OFF, 8'ha0);
        wr(VALL_OFF, 8'h05);
        rd("cfg after load", CFG_OFF, 8'ha0);
        repeat (22) @(posedge hclk);
        rd("half set", CFG_OFF, 8'ha8);
        rd("prescaler cleared", VALL_OFF, 8'h05);
        k = 0;
        do begin
            bus(1'b0, CFG_OFF, 32'h0);
            k++;
        end while (rdv[CFG_SYNC_BIT] !== 1'b1 && k < 20);
        chk("sync seen", {31'h0, rdv[CFG_SYNC_BIT]}, 32'h1);
        repeat (10) @(posedge hclk);
        rd("sec resumed", VALL_OFF, 8'h06);
        rd("sec reread", VALL_OFF, 8'h06);
        test_done();
    end
endmodule : tb_cca_clock_access
